// File: common/acfr_defs.svh
// register map, field positions, reset values and timing counts
`ifndef ACFR_DEFS_SVH
`define ACFR_DEFS_SVH
`define ACFR_ADDR_CTRL 4'h0
`define ACFR_ADDR_FILT 4'h4
`define ACFR_ADDR_SETUP 4'h8
`define ACFR_ADDR_STAT 4'hC
`define ACFR_CTRL_MASK 32'h0000007F
`define ACFR_FILT_MASK 32'h00037FF7
`define ACFR_CTRL_RESET 32'h00000000
`define ACFR_FILT_RESET 32'h00000010
`define ACFR_SETUP_RESET 32'h00000000
// control register fields
`define ACFR_CTRL_MCLK_LSB 0
`define ACFR_CTRL_REFEN 2
`define ACFR_CTRL_REFLVL 3
`define ACFR_CTRL_HOLDER 4
`define ACFR_CTRL_CORE 5
`define ACFR_CTRL_INTPIN 6
// filter register fields
`define ACFR_FILT_TYPE_LSB 0
`define ACFR_FILT_DEC_LSB 4
`define ACFR_FILT_POST_LSB 16
// filter type codes
`define ACFR_FT_SINC4 3'h0
`define ACFR_FT_SINC4AVG 3'h1
`define ACFR_FT_SINC3 3'h2
`define ACFR_FT_SINC3REJ 3'h3
`define ACFR_FT_SINC3AVG 3'h4
`define ACFR_FT_SINC3POST 3'h5
// clock source selector codes
`define ACFR_MCLK_INT 2'h0
`define ACFR_MCLK_INT_OUT 2'h1
`define ACFR_MCLK_EXT 2'h2
`define ACFR_MCLK_EXT_DIV 2'h3
// decimation and rate figures
`define ACFR_SINC4_DEC_MAX 11'h00A
`define ACFR_DEC_BASE 32
`define ACFR_AVG_LEN 8
`define ACFR_SINC4_AVG_MUL (4 + `ACFR_AVG_LEN - 1)
`define ACFR_SINC3_AVG_MUL (3 + `ACFR_AVG_LEN - 1)
`define ACFR_MCLK_HZ 76800
// post filter output rates in milli samples per second
`define ACFR_POST1_MSPS 26087
`define ACFR_POST2_MSPS 24000
`define ACFR_POST3_MSPS 19355
`define ACFR_POST4_MSPS 16210
// post filter periods rounded to the nearest master tick
`define ACFR_POST_TICKS(r) ((`ACFR_MCLK_HZ * 1000 + (r) / 2) / (r))
`endif

// File: common/acfr_pkg.sv
// types shared by the converter control block
package acfr_pkg;
    typedef enum logic [2:0] {
        ACFR_SINC4, ACFR_SINC4AVG, ACFR_SINC3, ACFR_SINC3REJ,
        ACFR_SINC3AVG, ACFR_SINC3POST
    } acfr_filter_e;
    typedef struct packed {
        logic refPowerOn;
        logic refLevelLow;
        logic standbyHolderEn;
        logic standbyCoreEn;
        logic [1:0] activeRefSel;
        logic activeBufEn;
    } acfr_ref_s;
    typedef struct packed {
        logic mclk;
        logic modClk;
        logic convStrobe;
    } acfr_clk_s;
endpackage

// File: src/acfr_control.sv
// clock, filter rate and reference control with an AHB-Lite register slave
//
// How it works
// - two-bit selector picks master clock source
// - internal oscillator after reset, optionally driven out
// - external clock used directly or halved
// - modulator clock runs at half master clock
// - sinc4 decimation 1..10, period 32 times decimation
// - sinc4 averaging period multiplied by eleven
// - sinc3 averaging decimation to 2047, times ten
// - sinc3 sixty hertz option, decimation 48 gives 50
// - post filter mode ignores decimation, four rates
// - interrupt routed to clock pin wins
// - internal reference off until enable bit set
// - level bit selects 1.25 V, only when enabled
// - each setup selects its reference source
// - each setup enables or bypasses reference buffer
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`include "acfr_defs.svh"
module acfr_control
    import acfr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // clock sources and clock pin
    input wire logic oscIn,
    input wire logic clkPinIn,
    output logic clkPinOut,
    output logic clkPinOeN,
    // interrupt to be routed to the clock pin
    input wire logic irqIn,
    // setup in use by the sequencer
    input wire logic [2:0] activeSetup,
    // derived clocks and reference controls
    output acfr_clk_s clkOut,
    output acfr_ref_s reference_output_pin
);
    // ==========================================================
    // register bus
    logic [31:0] ctrlReg;
    logic [31:0] filtReg;
    logic [31:0] setupReg;
    logic [15:0] convCount;
    logic wrPend;
    logic [3:0] wrAddr;
    logic filtChanged;
    wire addrPhase = hsel && hready && htrans[1];
    // only the first sixteen bytes are mapped, the rest reads zero
    wire addrHit = haddr[31:4] == 28'h0000000;
    wire [3:0] wordAddr = {haddr[3:2], 2'b00};
    wire wrCtrl = wrPend && wrAddr == `ACFR_ADDR_CTRL;
    wire wrFilt = wrPend && wrAddr == `ACFR_ADDR_FILT;
    wire wrSetup = wrPend && wrAddr == `ACFR_ADDR_SETUP;
    wire [31:0] ctrlWr = hwdata & `ACFR_CTRL_MASK;
    wire [31:0] filtWr = hwdata & `ACFR_FILT_MASK;
    logic [1:0] activeSel;
    logic mclk;
    wire [31:0] statWord = {convCount, 13'h0000, mclk, activeSel};
    wire [31:0] readMux = !addrHit ? 32'h00000000 :
        (wordAddr == `ACFR_ADDR_CTRL) ? ctrlReg :
        (wordAddr == `ACFR_ADDR_FILT) ? filtReg :
        (wordAddr == `ACFR_ADDR_SETUP) ? setupReg :
        (wordAddr == `ACFR_ADDR_STAT) ? statWord : 32'h00000000;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend <= 1'b0;
            wrAddr <= 4'h0;
            hrdata <= 32'h00000000;
        end else begin
            wrPend <= addrPhase && hwrite && addrHit;
            wrAddr <= wordAddr;
            if (addrPhase && !hwrite) begin
                hrdata <= readMux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlReg <= `ACFR_CTRL_RESET;
            filtReg <= `ACFR_FILT_RESET;
            setupReg <= `ACFR_SETUP_RESET;
            filtChanged <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrlReg <= ctrlWr;
            end
            if (wrSetup) begin
                setupReg <= hwdata;
            end
            if (wrFilt) begin
                filtReg <= filtWr;
            end
            filtChanged <= wrFilt && filtWr != filtReg;
        end
    end

    // ==========================================================
    // pin synchronisers
    wire [1:0] syncB;
    wire [1:0] rawPins = {clkPinIn, oscIn};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            logic stage1;
            logic stage2;
            always_ff @(posedge clk) begin
                if (rst) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= rawPins[gi];
                    stage2 <= stage1;
                end
            end
            assign syncB[gi] = stage2;
        end
    endgenerate
    wire oscS = syncB[0];
    wire extS = syncB[1];

    // ==========================================================
    // master and modulator clock
    logic prevSrc;
    logic modClk;
    wire [1:0] reqSel = ctrlReg[`ACFR_CTRL_MCLK_LSB +: 2];
    wire srcLevel = activeSel[1] ? extS : oscS;
    wire srcRise = srcLevel && !prevSrc;
    wire srcFall = !srcLevel && prevSrc;
    wire divide = activeSel == `ACFR_MCLK_EXT_DIV;
    wire next_mclk = divide ? (srcRise ? !mclk : mclk) :
        (srcRise ? 1'b1 : (srcFall ? 1'b0 : mclk));
    // switch only while the master clock is low, then await a fresh rise
    wire doSwitch = reqSel != activeSel && !mclk && !next_mclk;
    wire mclkTick = next_mclk && !mclk;

    always_ff @(posedge clk) begin
        if (rst) begin
            activeSel <= `ACFR_MCLK_INT;
            prevSrc <= 1'b1;
            mclk <= 1'b0;
            modClk <= 1'b0;
        end else if (doSwitch) begin
            activeSel <= reqSel;
            prevSrc <= 1'b1;
        end else begin
            prevSrc <= srcLevel;
            mclk <= next_mclk;
            if (mclkTick) begin
                modClk <= !modClk;
            end
        end
    end

    // ==========================================================
    // output rate from filter type and decimation
    wire [2:0] fType = filtReg[`ACFR_FILT_TYPE_LSB +: 3];
    wire [10:0] decRaw = filtReg[`ACFR_FILT_DEC_LSB +: 11];
    wire [1:0] postSel = filtReg[`ACFR_FILT_POST_LSB +: 2];
    wire sinc4Mode = fType == `ACFR_FT_SINC4 || fType == `ACFR_FT_SINC4AVG;
    wire [10:0] decEff = (decRaw == 11'h000) ? 11'h001 :
        ((sinc4Mode && decRaw > `ACFR_SINC4_DEC_MAX) ?
        `ACFR_SINC4_DEC_MAX : decRaw);
    wire [19:0] base = 20'(decEff) * 20'(`ACFR_DEC_BASE);
    wire [19:0] postTicks =
        (postSel == 2'h0) ? 20'(`ACFR_POST_TICKS(`ACFR_POST1_MSPS)) :
        (postSel == 2'h1) ? 20'(`ACFR_POST_TICKS(`ACFR_POST2_MSPS)) :
        (postSel == 2'h2) ? 20'(`ACFR_POST_TICKS(`ACFR_POST3_MSPS)) :
        20'(`ACFR_POST_TICKS(`ACFR_POST4_MSPS));
    logic [19:0] period;
    always_comb begin
        unique case (fType)
            `ACFR_FT_SINC4AVG: period = base * 20'(`ACFR_SINC4_AVG_MUL);
            `ACFR_FT_SINC3AVG: period = base * 20'(`ACFR_SINC3_AVG_MUL);
            `ACFR_FT_SINC3POST: period = postTicks;
            default: period = base;
        endcase
    end

    logic [19:0] decCount;
    logic convStrobe;
    wire lastTick = decCount >= period - 20'h00001;
    always_ff @(posedge clk) begin
        if (rst) begin
            decCount <= 20'h00000;
            convStrobe <= 1'b0;
            convCount <= 16'h0000;
        end else if (filtChanged) begin
            decCount <= 20'h00000;
            convStrobe <= 1'b0;
        end else begin
            convStrobe <= mclkTick && lastTick;
            if (mclkTick) begin
                decCount <= lastTick ? 20'h00000 : decCount + 20'h00001;
            end
            if (mclkTick && lastTick) begin
                convCount <= convCount + 16'h0001;
            end
        end
    end
    assign clkOut = '{mclk: mclk, modClk: modClk, convStrobe: convStrobe};

    // ==========================================================
    // clock pin
    wire intPinSel = ctrlReg[`ACFR_CTRL_INTPIN];
    always_ff @(posedge clk) begin
        if (rst) begin
            clkPinOut <= 1'b0;
            clkPinOeN <= 1'b1;
        end else if (intPinSel) begin
            clkPinOut <= irqIn;
            clkPinOeN <= 1'b0;
        end else begin
            clkPinOut <= oscS;
            clkPinOeN <= reqSel != `ACFR_MCLK_INT_OUT;
        end
    end

    // ==========================================================
    // reference control
    wire [3:0] setupField = setupReg[{activeSetup, 2'b00} +: 4];
    wire refEn = ctrlReg[`ACFR_CTRL_REFEN];
    always_ff @(posedge clk) begin
        if (rst) begin
            reference_output_pin <= '0;
        end else begin
            reference_output_pin.refPowerOn <= refEn;
            reference_output_pin.refLevelLow <= refEn && ctrlReg[`ACFR_CTRL_REFLVL];
            reference_output_pin.standbyHolderEn <= ctrlReg[`ACFR_CTRL_HOLDER];
            reference_output_pin.standbyCoreEn <= ctrlReg[`ACFR_CTRL_CORE];
            reference_output_pin.activeRefSel <= setupField[1:0];
            reference_output_pin.activeBufEn <= setupField[2];
        end
    end

    // ==========================================================
    // checks
    AST_CLK_OUT: assert property (@(posedge clk) disable iff (rst)
        !intPinSel && reqSel == `ACFR_MCLK_INT_OUT |=>
        !clkPinOeN && clkPinOut == $past(oscS))
        else $error("oscillator not driven on clock pin");
    AST_INT_PRIO: assert property (@(posedge clk) disable iff (rst)
        intPinSel |=> !clkPinOeN && clkPinOut == $past(irqIn))
        else $error("interrupt routing lost priority");
    AST_DIV_TWO: assert property (@(posedge clk) disable iff (rst)
        divide && !doSwitch && srcRise |=> mclk != $past(mclk))
        else $error("divided clock missed a toggle");
    AST_MOD_HALF: assert property (@(posedge clk) disable iff (rst)
        $changed(modClk) |-> $past(mclkTick))
        else $error("modulator clock moved without master edge");
    AST_NO_RUNT: assert property (@(posedge clk) disable iff (rst)
        $changed(activeSel) |-> !mclk ##1 !mclk)
        else $error("source switched during high phase");
    AST_REF_OFF: assert property (@(posedge clk) disable iff (rst)
        !refEn |=> !reference_output_pin.refPowerOn && !reference_output_pin.refLevelLow)
        else $error("reference powered while disabled");
    AST_LEVEL: assert property (@(posedge clk) disable iff (rst)
        reference_output_pin.refLevelLow |-> reference_output_pin.refPowerOn)
        else $error("level bit active with reference off");
    AST_SINC4_CLAMP: assert property (@(posedge clk) disable iff (rst)
        sinc4Mode |-> decEff <= `ACFR_SINC4_DEC_MAX && decEff != 11'h000)
        else $error("sinc4 decimation out of range");
    AST_AVG4: assert property (@(posedge clk) disable iff (rst)
        fType == `ACFR_FT_SINC4AVG |-> period == 20'(decEff) * 20'h00160)
        else $error("sinc4 averaging period wrong");
    AST_AVG3: assert property (@(posedge clk) disable iff (rst)
        fType == `ACFR_FT_SINC3AVG |-> period == 20'(decEff) * 20'h00140)
        else $error("sinc3 averaging period wrong");
    AST_SIXTY_HZ_REJECT_OPTION: assert property (@(posedge clk) disable iff (rst)
        fType == `ACFR_FT_SINC3REJ && decRaw == 11'h030 |->
        period == 20'h00600)
        else $error("fifty and sixty hertz setting wrong rate");
    AST_POST: assert property (@(posedge clk) disable iff (rst)
        fType == `ACFR_FT_SINC3POST |->
        period inside {20'h00B80, 20'h00C80, 20'h00F80, 20'h01282})
        else $error("post filter rate not one of four");
    AST_RESTART: assert property (@(posedge clk) disable iff (rst)
        filtChanged |=> decCount == 20'h00000 && !convStrobe)
        else $error("decimation count not restarted");
    AST_SETUP_REF: assert property (@(posedge clk) disable iff (rst)
        $stable(setupReg) && $stable(activeSetup) |=>
        reference_output_pin.activeRefSel == $past(setupField[1:0]))
        else $error("setup reference select not applied");
endmodule

// File: testbench/acfr_clk_source.sv
// clock sources standing outside the converter control block
`timescale 1ns/1ns
module acfr_clk_source #(
    parameter int INT_HALF = 150,
    parameter int EXT_HALF = 250
) (
    // request for the doubled external rate
    input wire logic extFast,
    // generated clocks
    output logic oscIn,
    output logic extClk
);
    // oscillator offset so its edges never meet the system clock edges
    initial begin
        oscIn = 1'b0;
        #20;
        forever #(INT_HALF) oscIn = ~oscIn;
    end
    // external source runs free, twice as fast when the device halves it
    initial begin
        extClk = 1'b0;
        #30;
        forever #(extFast ? EXT_HALF / 2 : EXT_HALF) extClk = ~extClk;
    end
endmodule

// File: testbench/test_adc_clock_filter_ref_control.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`include "acfr_defs.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    err_count++; $display("unexpected %s: expected %h seen %h", nm, ex, got); \
    end end
module test_adc_clock_filter_ref_control;
    import acfr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b1;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, clkPinOut, clkPinOeN, oscIn, extClk;
    logic extFast = 1'b0;
    logic irqIn = 1'b0;
    logic [2:0] activeSetup = 3'h0;
    logic [31:0] hrdata, rd, sv;
    acfr_clk_s clkOut;
    acfr_ref_s reference_output_pin;
    int err_count = 0;
    int check_count = 0;
    int n, m, d;
    // filter settings and their periods in master ticks
    logic [31:0] fv [10] = '{32'h000000A0, 32'h000000B0, 32'h00000011,
        32'h00000022, 32'h00000303, 32'h00000014, 32'h00000055,
        32'h00010055, 32'h00020055, 32'h00030055};
    int tk [10] = '{320, 320, 352, 64, 1536, 320, 2944, 3200, 3968, 4738};
    // pin level from both drivers
    wire clkPin = (clkPinOeN === 1'b0) ? clkPinOut : extClk;

    always #50 clk = ~clk;

    acfr_control DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .oscIn(oscIn), .clkPinIn(clkPin),
        .clkPinOut(clkPinOut), .clkPinOeN(clkPinOeN), .irqIn(irqIn),
        .activeSetup(activeSetup), .clkOut(clkOut), .reference_output_pin(reference_output_pin));
    acfr_clk_source SRC (.extFast(extFast), .oscIn(oscIn), .extClk(extClk));

    // ==========================================================
    // bus tasks
    task automatic busCycle(input logic [31:0] a, input logic w,
        input logic [31:0] dat);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= dat;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        `CHK("response", 1'b0, hresp)
        @(posedge clk);
    endtask

    task automatic busWrite(input logic [31:0] a, input logic [31:0] dat);
        busCycle(a, 1'b1, dat);
        // registered outputs follow the landed write one edge later
        @(posedge clk);
    endtask

    task automatic checkReg(input logic [31:0] a, input logic [31:0] e);
        busCycle(a, 1'b0, 32'h0);
        `CHK("register", e, rd)
    endtask

    // ==========================================================
    // clock observation tasks
    task automatic countRise(input int cyc, input bit pin, output int c);
        logic p, v;
        p = 1'b1;
        c = 0;
        repeat (cyc) begin
            @(posedge clk);
            v = pin ? clkPinOut : clkOut.mclk;
            if (v === 1'b1 && p === 1'b0) c++;
            p = v;
        end
    endtask

    task automatic toStrobe(output int mt, output int dt);
        int k;
        logic p, q;
        mt = 0;
        dt = 0;
        k = 0;
        p = clkOut.mclk;
        q = clkOut.modClk;
        do begin
            @(posedge clk);
            k++;
            if (clkOut.mclk === 1'b1 && p === 1'b0) mt++;
            if (clkOut.modClk === 1'b1 && q === 1'b0) dt++;
            p = clkOut.mclk;
            q = clkOut.modClk;
        end while (clkOut.convStrobe !== 1'b1 && k < 60000);
    endtask

    function automatic bit near(input int v, input int e);
        return v >= e - 2 && v <= e + 2;
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        test_done();
    end

    // ==========================================================
    // test sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        `CHK("ref outputs", 7'h00, reference_output_pin)
        `CHK("pin enable", 1'b1, clkPinOeN)
        checkReg(`ACFR_ADDR_CTRL, `ACFR_CTRL_RESET);
        checkReg(`ACFR_ADDR_FILT, `ACFR_FILT_RESET);
        checkReg(`ACFR_ADDR_SETUP, `ACFR_SETUP_RESET);
        checkReg(32'h00000010, 32'h0);
        countRise(300, 1'b0, n);
        `CHK("internal rate", 1'b1, near(n, 100))
        $display("test reset done");

        busWrite(`ACFR_ADDR_CTRL, 32'h00000008);
        `CHK("ref power", 1'b0, reference_output_pin.refPowerOn)
        `CHK("ref level", 1'b0, reference_output_pin.refLevelLow)
        busWrite(`ACFR_ADDR_CTRL, 32'h0000003C);
        `CHK("ref bits", 4'hF, reference_output_pin[6:3])
        busWrite(`ACFR_ADDR_CTRL, 32'h00000000);
        `CHK("ref off", 1'b0, reference_output_pin.refPowerOn)
        for (int i = 0; i < 8; i++) begin
            sv[4 * i +: 4] = {1'b0, i[0], 2'(i % 3)};
        end
        busWrite(`ACFR_ADDR_SETUP, sv);
        for (int i = 0; i < 8; i++) begin
            activeSetup <= 3'(i);
            repeat (3) @(posedge clk);
            `CHK("ref source", 2'(i % 3), reference_output_pin.activeRefSel)
            `CHK("ref buffer", i[0], reference_output_pin.activeBufEn)
        end
        $display("test reference done");

        busWrite(`ACFR_ADDR_CTRL, 32'hFFFFFFFF);
        checkReg(`ACFR_ADDR_CTRL, `ACFR_CTRL_MASK);
        checkReg(32'h00000010, 32'h00000000);
        irqIn <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("irq pin", 2'b01, {clkPinOeN, clkPinOut})
        irqIn <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("irq pin low", 2'b00, {clkPinOeN, clkPinOut})
        busWrite(`ACFR_ADDR_CTRL, 32'h00000001);
        countRise(300, 1'b1, n);
        `CHK("pin rate", 1'b1, near(n, 100))
        busWrite(`ACFR_ADDR_CTRL, 32'h00000002);
        `CHK("pin released", 1'b1, clkPinOeN)
        countRise(500, 1'b0, n);
        `CHK("external rate", 1'b1, near(n, 100))
        busCycle(`ACFR_ADDR_STAT, 1'b0, 32'h00000000);
        `CHK("active source", 2'h2, rd[1:0])
        extFast <= 1'b1;
        busWrite(`ACFR_ADDR_CTRL, 32'h00000003);
        countRise(500, 1'b0, n);
        `CHK("halved rate", 1'b1, near(n, 100))
        extFast <= 1'b0;
        busWrite(`ACFR_ADDR_CTRL, 32'h00000000);
        $display("test clock pin done");

        for (int i = 0; i < 10; i++) begin
            busWrite(`ACFR_ADDR_FILT, fv[i]);
            toStrobe(m, d);
            `CHK("first period", tk[i], m)
            if (tk[i] < 2000) begin
                toStrobe(m, d);
                `CHK("period", tk[i], m)
                `CHK("modulator ticks", tk[i] / 2, d)
            end else begin
                `CHK("post modulator", tk[i] / 2, d)
            end
        end
        $display("test rates done");
        test_done();
    end
endmodule
